// >>> design/fpec_params.svh
// Purpose: Constants for the flash program/erase control block.
// Assumes: Byte address of a register is four times its index.
// Notes:   Indices keep the printed register offsets.
`ifndef FPEC_PARAMS_SVH
`define FPEC_PARAMS_SVH

`define FPEC_IDX_MODE     32'hffffe800
`define FPEC_IDX_ERR      32'hffffe801
`define FPEC_IDX_EBLO     32'hffffe802
`define FPEC_IDX_EBHI     32'hffffe803
`define FPEC_IDX_OVL      32'hffffec26
`define FPEC_ADDR_MODE    (`FPEC_IDX_MODE << 2)
`define FPEC_ADDR_ERR     (`FPEC_IDX_ERR << 2)
`define FPEC_ADDR_EBLO    (`FPEC_IDX_EBLO << 2)
`define FPEC_ADDR_EBHI    (`FPEC_IDX_EBHI << 2)
`define FPEC_ADDR_OVL     (`FPEC_IDX_OVL << 2)

`define FPEC_BIT_HWP      7
`define FPEC_BIT_SWP      6
`define FPEC_BIT_ESU      5
`define FPEC_BIT_PSU      4
`define FPEC_BIT_EV       3
`define FPEC_BIT_PV       2
`define FPEC_BIT_EGO      1
`define FPEC_BIT_PGO      0
`define FPEC_BIT_ERR      7
`define FPEC_BIT_RAMS     3

`define FPEC_MODE_RST_HI  8'h80
`define FPEC_MODE_RST_LO  8'h00
`define FPEC_REG_RST      8'h00
`define FPEC_EBHI_RST     4'h0
`define FPEC_OVL_RST      4'h0

`define FPEC_STRB_BYTE    4'h1
`define FPEC_STRB_LONG    4'hf
`define FPEC_CYC_SHORT    3
`define FPEC_CYC_LONG     6
`define FPEC_SYNC_W       2

`endif

// >>> design/fpec_pkg.sv
// Purpose: Types for the flash program/erase control block.
// Assumes: Nothing beyond the parameter header.
// Notes:   States and selectors carry no fixed codes.
package fpec_pkg;

   typedef enum logic [1:0] {
      FPEC_ST_IDLE,
      FPEC_ST_WAIT,
      FPEC_ST_DONE
   } fpec_apb_state_e;

   typedef enum logic [2:0] {
      FPEC_REG_NONE,
      FPEC_REG_MODE,
      FPEC_REG_ERR,
      FPEC_REG_EBLO,
      FPEC_REG_EBHI,
      FPEC_REG_OVL
   } fpec_reg_e;

   typedef enum logic [2:0] {
      FPEC_OP_OFF,
      FPEC_OP_IDLE,
      FPEC_OP_PROGRAM,
      FPEC_OP_ERASE,
      FPEC_OP_PROGRAM_VERIFY,
      FPEC_OP_ERASE_VERIFY
   } fpec_op_e;

endpackage

// >>> design/fpec_sync_if.sv
// Purpose: Carries raw pin levels to the synchroniser and filtered levels back.
// Assumes: Bit 0 is the hardware permit pin, bit 1 the flash enable strap.
// Notes:   Width comes from the parameter header.
`timescale 1ns/10ps
`include "fpec_params.svh"

interface fpec_sync_if;
   logic [`FPEC_SYNC_W-1:0] raw;
   logic [`FPEC_SYNC_W-1:0] filt;
   modport sync (input raw, output filt);
   modport user (output raw, input filt);
endinterface // fpec_sync_if

// >>> design/fpec_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for board pins.
// Assumes: Pins are asynchronous to clk.
// Notes:   Chain is not reset so that pin levels are valid during reset.
`timescale 1ns/10ps
`include "fpec_params.svh"

module fpec_pin_sync (
   input wire logic clk,     // System clock.
   input wire logic ce,      // Clock enable.
   fpec_sync_if.sync sif     // Raw in, filtered out.
);

   logic [`FPEC_SYNC_W-1:0] stage1;
   logic [`FPEC_SYNC_W-1:0] stage2;
   logic [`FPEC_SYNC_W-1:0] stage3;

   always_ff @(posedge clk) begin
      if (ce) begin
         stage1 <= sif.raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // A level is accepted only once the second and third stages agree.
   always_ff @(posedge clk) begin
      if (ce) begin
         sif.filt <= (stage2 & stage3) | (sif.filt & (stage2 ^ stage3));
      end
   end

endmodule // fpec_pin_sync

// >>> design/fpec_top.sv
// Purpose: Flash program/erase mode control registers behind an APB slave.
// Assumes: Pins are synchronised here; standby and fault inputs are on clk.
// Notes:   Hold nrst for at least four edges so pin levels are settled.
//
// How it works
// - Mode register bit 7 reads the filtered hardware permit pin.
// - Mode register resets to 80h with pin high, 00h with pin low.
// - Power-on reset and both standby entries return the mode register to reset.
// - With flash disabled, the four control registers read zero and ignore writes.
// - Software permit bit is writable only while the hardware permit is high.
// - Setup and verify bits are writable only with both permits high.
// - Erase-go sets only with both permits and erase-setup high; starts erase unless program-go is also set.
// - Program-go sets only with both permits and program-setup high; starts program.
// - Control registers take byte accesses in 3 cycles; overlay longword write takes 6.
// - Both block select registers are cleared unless both permits are high.
// - More than one block select bit set clears both select registers.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`include "fpec_params.svh"

module fpec_top (
   input  wire logic               clk,                   // System clock, 10 MHz.
   input  wire logic               nrst,                  // Synchronous power-on reset.
   input  wire logic               ce,                    // Clock enable.
   input  wire logic               psel,                  // APB select.
   input  wire logic               penable,               // APB enable.
   input  wire logic               pwrite,                // APB direction.
   input  wire logic [31:0]        paddr,                 // APB byte address.
   input  wire logic [31:0]        pwdata,                // APB write data.
   input  wire logic [3:0]         pstrb,                 // APB byte strobes.
   output logic      [31:0]        prdata,                // APB read data.
   output logic                    pready,                // APB ready.
   output logic                    pslverr,               // APB error.
   input  wire logic               hw_program_permit_pin, // Board write-permit pin.
   input  wire logic               flash_on_pin,          // Flash enabled by mode straps.
   input  wire logic               hw_standby,            // Hardware standby level.
   input  wire logic               sw_standby,            // Software standby level.
   input  wire logic               flash_fault,           // Program or erase error event.
   output fpec_pkg::fpec_op_e      flash_op,              // Current flash operating mode.
   output logic      [11:0]        erase_blocks,          // Selected erase block.
   output logic      [3:0]         overlay_sel            // Overlay select and area.
);

   import fpec_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.

   fpec_sync_if sif ();

   logic hwp;
   logic fon;

   assign sif.raw = {flash_on_pin, hw_program_permit_pin};
   assign hwp     = sif.filt[0];
   assign fon     = sif.filt[1];

   fpec_pin_sync u_sync (
      .clk (clk),
      .ce  (ce),
      .sif (sif.sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Address decode and access checks.

   function automatic fpec_reg_e decode(input logic [31:0] addr);
      case (addr)
         `FPEC_ADDR_MODE: decode = FPEC_REG_MODE;
         `FPEC_ADDR_ERR:  decode = FPEC_REG_ERR;
         `FPEC_ADDR_EBLO: decode = FPEC_REG_EBLO;
         `FPEC_ADDR_EBHI: decode = FPEC_REG_EBHI;
         `FPEC_ADDR_OVL:  decode = FPEC_REG_OVL;
         default:         decode = FPEC_REG_NONE;
      endcase
   endfunction

   function automatic logic access_ok(input fpec_reg_e r, input logic wr, input logic [3:0] strb);
      case (r)
         FPEC_REG_NONE: access_ok = 1'b0;
         FPEC_REG_OVL:  access_ok = !wr || (strb != 4'h0);
         default:       access_ok = !wr || (strb == `FPEC_STRB_BYTE);
      endcase
   endfunction

   function automatic logic many_set(input logic [11:0] v);
      many_set = (v & (v - 12'h001)) != 12'h000;
   endfunction

   fpec_apb_state_e st;
   logic [2:0]      cnt;
   fpec_reg_e       sel;
   logic            ok;
   logic            wr_done;
   logic [7:0]      wd;

   assign sel     = decode(paddr);
   assign ok      = access_ok(sel, pwrite, pstrb);
   assign wr_done = (st == FPEC_ST_DONE) && psel && penable && pwrite && !pslverr;
   assign wd      = pwdata[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Register state.

   logic       swp;
   logic       esu;
   logic       psu;
   logic       ev;
   logic       pv;
   logic       ego;
   logic       pgo;
   logic [7:0] eb_lo;
   logic [3:0] eb_hi;
   logic       err;
   logic [3:0] ovl;

   logic wr_mode;
   logic wr_eblo;
   logic wr_ebhi;
   logic wr_ovl;

   assign wr_mode = wr_done && fon && (sel == FPEC_REG_MODE);
   assign wr_eblo = wr_done && fon && (sel == FPEC_REG_EBLO);
   assign wr_ebhi = wr_done && fon && (sel == FPEC_REG_EBHI);
   assign wr_ovl  = wr_done && (sel == FPEC_REG_OVL) && pstrb[0];

   // Gates use the values held before the write, so a write that sets a bit
   // and the bit it enables only takes the first step.
   always_ff @(posedge clk) begin
      if (!nrst || hw_standby || sw_standby) begin
         swp <= 1'b0;
         esu <= 1'b0;
         psu <= 1'b0;
         ev  <= 1'b0;
         pv  <= 1'b0;
         ego <= 1'b0;
         pgo <= 1'b0;
      end else if (ce) begin
         if (!hwp) begin
            swp <= 1'b0;
            esu <= 1'b0;
            psu <= 1'b0;
            ev  <= 1'b0;
            pv  <= 1'b0;
            ego <= 1'b0;
            pgo <= 1'b0;
         end else begin
            if (wr_mode) begin
               swp <= wd[`FPEC_BIT_SWP];
               if (swp) begin
                  esu <= wd[`FPEC_BIT_ESU];
                  psu <= wd[`FPEC_BIT_PSU];
                  ev  <= wd[`FPEC_BIT_EV];
                  pv  <= wd[`FPEC_BIT_PV];
               end
               if (swp && esu) begin
                  ego <= wd[`FPEC_BIT_EGO];
               end
               if (swp && psu) begin
                  pgo <= wd[`FPEC_BIT_PGO];
               end
            end
            // Dropping an enabling bit also drops what it enabled.
            if (!swp) begin
               esu <= 1'b0;
               psu <= 1'b0;
               ev  <= 1'b0;
               pv  <= 1'b0;
               ego <= 1'b0;
               pgo <= 1'b0;
            end
            if (!esu) begin
               ego <= 1'b0;
            end
            if (!psu) begin
               pgo <= 1'b0;
            end
         end
      end
   end

   logic [11:0] next_eb;

   assign next_eb = {wr_ebhi ? wd[3:0] : eb_hi, wr_eblo ? wd : eb_lo};

   always_ff @(posedge clk) begin
      if (!nrst || hw_standby || sw_standby) begin
         eb_lo <= `FPEC_REG_RST;
         eb_hi <= `FPEC_EBHI_RST;
      end else if (ce) begin
         if (!hwp || !swp) begin
            eb_lo <= `FPEC_REG_RST;
            eb_hi <= `FPEC_EBHI_RST;
         end else if (wr_eblo || wr_ebhi) begin
            if (many_set(next_eb)) begin
               eb_lo <= `FPEC_REG_RST;
               eb_hi <= `FPEC_EBHI_RST;
            end else begin
               eb_lo <= next_eb[7:0];
               eb_hi <= next_eb[11:8];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || hw_standby) begin
         err <= 1'b0;
      end else if (ce && flash_fault) begin
         err <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || hw_standby) begin
         ovl <= `FPEC_OVL_RST;
      end else if (ce && wr_ovl) begin
         ovl <= pwdata[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data.

   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (sel)
         FPEC_REG_MODE: begin
            if (fon) begin
               next_rdata[7:0] = {hwp, swp, esu, psu, ev, pv, ego, pgo};
            end
         end
         FPEC_REG_ERR: begin
            if (fon) begin
               next_rdata[`FPEC_BIT_ERR] = err;
            end
         end
         FPEC_REG_EBLO: begin
            if (fon) begin
               next_rdata[7:0] = eb_lo;
            end
         end
         FPEC_REG_EBHI: begin
            if (fon) begin
               next_rdata[3:0] = eb_hi;
            end
         end
         FPEC_REG_OVL: begin
            next_rdata[3:0] = ovl;
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: wait states give 3 cycles, or 6 for a longword overlay write.

   logic long_acc;

   assign long_acc = (sel == FPEC_REG_OVL) && pwrite && (pstrb == `FPEC_STRB_LONG);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st      <= FPEC_ST_IDLE;
         cnt     <= 3'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         case (st)
            FPEC_ST_IDLE: begin
               if (psel && !penable) begin
                  cnt <= long_acc ? 3'(`FPEC_CYC_LONG - 2) : 3'(`FPEC_CYC_SHORT - 2);
                  st  <= FPEC_ST_WAIT;
               end
            end
            FPEC_ST_WAIT: begin
               if (cnt == 3'h1) begin
                  pready  <= 1'b1;
                  pslverr <= !ok;
                  prdata  <= ok ? next_rdata : 32'h0000_0000;
                  st      <= FPEC_ST_DONE;
               end
               cnt <= cnt - 3'h1;
            end
            FPEC_ST_DONE: begin
               if (psel && penable) begin
                  pready  <= 1'b0;
                  pslverr <= 1'b0;
                  prdata  <= 32'h0000_0000;
                  st      <= FPEC_ST_IDLE;
               end
            end
            default: begin
               st <= FPEC_ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   fpec_op_e next_op;

   always_comb begin
      if (!fon) begin
         next_op = FPEC_OP_OFF;
      end else if (pgo) begin
         next_op = FPEC_OP_PROGRAM;
      end else if (ego) begin
         next_op = FPEC_OP_ERASE;
      end else if (pv) begin
         next_op = FPEC_OP_PROGRAM_VERIFY;
      end else if (ev) begin
         next_op = FPEC_OP_ERASE_VERIFY;
      end else begin
         next_op = FPEC_OP_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         flash_op     <= FPEC_OP_OFF;
         erase_blocks <= 12'h000;
         overlay_sel  <= `FPEC_OVL_RST;
      end else if (ce) begin
         flash_op     <= next_op;
         erase_blocks <= {eb_hi, eb_lo};
         overlay_sel  <= ovl;
      end
   end

endmodule // fpec_top

// >>> tb/fpec_properties.sv
// Purpose: Port-level properties of the flash mode control block.
// Assumes: One clock domain, checks paused while nrst is low.
// Notes:   Bound to fpec_top after the module.
`timescale 1ns/10ps
`include "fpec_params.svh"

module fpec_properties (
   input wire logic               clk,                   // Clock.
   input wire logic               nrst,                  // Reset, active low.
   input wire logic               psel,                  // Select.
   input wire logic               penable,               // Enable.
   input wire logic               pwrite,                // Direction.
   input wire logic [31:0]        paddr,                 // Address.
   input wire logic [3:0]         pstrb,                 // Strobes.
   input wire logic [31:0]        prdata,                // Read data.
   input wire logic               pready,                // Ready.
   input wire logic               pslverr,               // Error.
   input wire logic               hw_program_permit_pin, // Permit pin.
   input wire logic               flash_on_pin,          // Flash enabled.
   input wire logic               sw_standby,            // Standby entry.
   input wire fpec_pkg::fpec_op_e flash_op,              // Operating mode.
   input wire logic [11:0]        erase_blocks           // Block select copy.
);
   import fpec_pkg::*;
   logic ovl_long;
   logic pin_on;
   logic rd_mode;
   assign ovl_long = pwrite && paddr == `FPEC_ADDR_OVL && pstrb == `FPEC_STRB_LONG;
   assign pin_on   = hw_program_permit_pin && flash_on_pin;
   assign rd_mode  = pready && !pwrite && !pslverr && paddr == `FPEC_ADDR_MODE;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   a_short_access: assert property (psel && !penable && !ovl_long |=> !pready ##1 pready)
      else $error("short access not three cycles");
   a_long_access: assert property (psel && !penable && ovl_long |=> !pready [*4] ##1 pready)
      else $error("long overlay write not six cycles");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_quiet_idle: assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("read data or error outside completion");
   a_error_no_data: assert property (pslverr |-> prdata == 32'h0)
      else $error("error with nonzero data");
   a_mode_pin_high: assert property (pin_on [*7] ##1 (pin_on && rd_mode) |-> prdata[7])
      else $error("mode bit 7 low with pin high");
   a_mode_pin_low: assert property ((!hw_program_permit_pin && flash_on_pin) [*7] ##1 rd_mode |-> prdata == 32'h0)
      else $error("mode register nonzero with pin low");
   a_one_block: assert property ($countones(erase_blocks) <= 1)
      else $error("more than one erase block selected");
   a_pin_low_blocks: assert property (!hw_program_permit_pin [*8] |-> erase_blocks == 12'h0)
      else $error("block select kept with pin low");
   a_reset_release: assert property ($rose(nrst) |-> flash_op == FPEC_OP_OFF && erase_blocks == 12'h0 && !pready)
      else $error("outputs not at reset state");
   a_standby_blocks: assert property (sw_standby |=> ##1 erase_blocks == 12'h0)
      else $error("block select kept after standby");
endmodule // fpec_properties

bind fpec_top fpec_properties fpec_properties_i (
   .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_program_permit_pin(hw_program_permit_pin),
   .flash_on_pin(flash_on_pin), .sw_standby(sw_standby), .flash_op(flash_op), .erase_blocks(erase_blocks)
);

// >>> tb/flash_program_erase_control_tb.sv
// Purpose: Self-checking bench for the flash program/erase control block.
// Assumes: APB driven here; a monitor compares each completion with its note.
// Notes:   Pin changes pass a synchroniser, so fixed waits follow them.
`timescale 1ns/10ps
`include "fpec_params.svh"

module flash_program_erase_control_tb;
   import fpec_pkg::*;
   localparam logic [31:0] ad_mode = `FPEC_ADDR_MODE;
   localparam logic [31:0] ad_err  = `FPEC_ADDR_ERR;
   localparam logic [31:0] ad_lo   = `FPEC_ADDR_EBLO;
   localparam logic [31:0] ad_hi   = `FPEC_ADDR_EBHI;
   localparam logic [31:0] ad_ovl  = `FPEC_ADDR_OVL;
   logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        pin = 1'b1, fon = 1'b1, hsb = 1'b0, ssb = 1'b0, fault = 1'b0, ce = 1'b1;
   logic        pready, pslverr;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
   logic [3:0]  pstrb = 4'h1, overlay_sel;
   logic [11:0] erase_blocks;
   logic [33:0] note;
   logic [33:0] expq[$];
   fpec_op_e    flash_op;
   int          n_errors = 0, compares = 0, k, j;
   // Erase-setup and erase-go refused before the permit, then permit, program-go refused, program then erase setup and go, then each verify bit.
   logic [7:0]  wv[14] = '{8'h20, 8'h02, 8'h40, 8'h41, 8'h50, 8'h51, 8'h40, 8'h60, 8'h62, 8'h40, 8'h48, 8'h40, 8'h44, 8'h40};
   logic [7:0]  rv[14] = '{8'h80, 8'h80, 8'hc0, 8'hc0, 8'hd0, 8'hd1, 8'hc0, 8'he0, 8'he2, 8'hc0, 8'hc8, 8'hc0, 8'hc4, 8'hc0};
   fpec_op_e    ov[14] = '{FPEC_OP_IDLE, FPEC_OP_IDLE, FPEC_OP_IDLE, FPEC_OP_IDLE, FPEC_OP_IDLE,
                           FPEC_OP_PROGRAM, FPEC_OP_IDLE,
                           FPEC_OP_IDLE, FPEC_OP_ERASE, FPEC_OP_IDLE, FPEC_OP_ERASE_VERIFY, FPEC_OP_IDLE,
                           FPEC_OP_PROGRAM_VERIFY, FPEC_OP_IDLE};

   always #50 clk = ~clk;

   fpec_top fpec_top_i (
      .clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hw_program_permit_pin(pin), .flash_on_pin(fon), .hw_standby(hsb), .sw_standby(ssb),
      .flash_fault(fault), .flash_op(flash_op), .erase_blocks(erase_blocks), .overlay_sel(overlay_sel)
   );

   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Holds the request until pready is sampled high, then idles one cycle.
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [31:0] exp, input logic err);
      int n;
      n = 0;
      expq.push_back({!w, err, exp});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_errors++;
         end_sim();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'h1, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'h1, e, 1'b0);
   endtask

   always @(posedge clk) begin
      if (nrst === 1'b1 && pready === 1'b1) begin
         if (expq.size() == 0) begin
            chk("pready", 32'h0, 32'h1);
         end else begin
            note = expq.pop_front();
            chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
            if (note[33]) begin
               chk("prdata", note[31:0], prdata);
            end
         end
      end
   end

   initial begin
      void'($urandom(32'h85f9c091));
      cyc(2);
      nrst <= 1'b1;
      cyc(1);
      rd(ad_mode, 32'h80);
      rd(ad_err, 32'h0);
      rd(ad_hi, 32'h0);
      rd(ad_ovl, 32'h0);
      wr(ad_lo, 32'h1);
      rd(ad_lo, 32'h0);
      $display("test reset done");
      for (k = 0; k < 14; k++) begin
         wr(ad_mode, ($urandom() & 32'hffffff00) | {24'h0, wv[k]});
         rd(ad_mode, {24'h0, rv[k]});
         chk("flash_op", {29'h0, ov[k]}, {29'h0, flash_op});
      end
      $display("test mode chain done");
      k = $urandom_range(11, 8);
      j = $urandom_range(7, 0);
      wr(ad_hi, 32'h1 << (k - 8));
      rd(ad_hi, 32'h1 << (k - 8));
      chk("erase_blocks", 32'h1 << k, {20'h0, erase_blocks});
      wr(ad_lo, 32'h1 << j);
      rd(ad_lo, 32'h0);
      rd(ad_hi, 32'h0);
      wr(ad_lo, 32'h1 << j);
      rd(ad_lo, 32'h1 << j);
      wr(ad_mode, 32'h0);
      rd(ad_mode, 32'h80);
      rd(ad_lo, 32'h0);
      $display("test block select done");
      apb(1'b1, ad_mode, 32'h40, `FPEC_STRB_LONG, 32'h0, 1'b1);
      rd(ad_mode, 32'h80);
      apb(1'b0, ad_ovl + 32'h10, 32'h0, 4'h1, 32'h0, 1'b1);
      wr(ad_err, 32'h80);
      rd(ad_err, 32'h0);
      apb(1'b1, ad_ovl, ($urandom() & 32'hfffffff0) | 32'hb, `FPEC_STRB_LONG, 32'h0, 1'b0);
      rd(ad_ovl, 32'hb);
      chk("overlay_sel", 32'hb, {28'h0, overlay_sel});
      $display("test access done");
      wr(ad_mode, 32'h40);
      wr(ad_lo, 32'h1 << j);
      fault <= 1'b1;
      cyc(1);
      fault <= 1'b0;
      ssb <= 1'b1;
      cyc(1);
      ssb <= 1'b0;
      cyc(2);
      rd(ad_mode, 32'h80);
      rd(ad_lo, 32'h0);
      rd(ad_ovl, 32'hb);
      rd(ad_err, 32'h80);
      hsb <= 1'b1;
      cyc(1);
      hsb <= 1'b0;
      cyc(2);
      rd(ad_ovl, 32'h0);
      rd(ad_err, 32'h0);
      chk("overlay_sel", 32'h0, {28'h0, overlay_sel});
      $display("test standby done");
      // A fault seen while the clock enable is low must not set the error flag.
      ce <= 1'b0;
      fault <= 1'b1;
      cyc(3);
      fault <= 1'b0;
      ce <= 1'b1;
      cyc(1);
      rd(ad_err, 32'h0);
      $display("test clock enable done");
      wr(ad_mode, 32'h40);
      pin <= 1'b0;
      cyc(10);
      rd(ad_mode, 32'h0);
      wr(ad_mode, 32'h40);
      rd(ad_mode, 32'h0);
      nrst <= 1'b0;
      cyc(4);
      nrst <= 1'b1;
      cyc(1);
      rd(ad_mode, 32'h0);
      pin <= 1'b1;
      cyc(10);
      rd(ad_mode, 32'h80);
      $display("test pin done");
      wr(ad_mode, 32'h40);
      fon <= 1'b0;
      cyc(10);
      rd(ad_mode, 32'h0);
      chk("flash_op", {29'h0, FPEC_OP_OFF}, {29'h0, flash_op});
      wr(ad_mode, 32'h0);
      fon <= 1'b1;
      cyc(10);
      rd(ad_mode, 32'hc0);
      $display("test flash off done");
      end_sim();
   end
endmodule // flash_program_erase_control_tb
